// [bench/hcg_config_regs_sva.sv]
// port-level checks for the configuration register slice
`timescale 1ns/1ps
`default_nettype none
module hcg_config_regs_chk
    import hcg_pkg::*;
(
    // clock and reset
    input wire logic     i_sys_clk,
    input wire logic     i_rst,
    // watched inputs
    input wire logic     i_spi_cs_n,
    input wire logic     i_fail_req,
    // watched outputs
    input wire logic     o_spi_miso_oe,
    input wire hcg_pin_t o_pin,
    input wire logic     o_wake_event,
    input wire hcg_cfg_t o_cfg,
    input wire logic     o_pwm_wrap
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);
    sequence s_cs_rise;
        $rose(i_spi_cs_n);
    endsequence
    chk_por_default: assert property ($fell(i_rst) |-> o_cfg == hcg_cfg_t'(7'h20))
        else $error("config not at default");
    chk_lock_freeze: assert property (o_cfg.lock1 |=> $stable(o_cfg))
        else $error("locked config moved");
    chk_cfg_at_cs: assert property ($changed(o_cfg) |-> $past(i_spi_cs_n, 3))
        else $error("config moved inside a frame");
    chk_oe_release: assert property (s_cs_rise |-> ##[1:8] !o_spi_miso_oe)
        else $error("miso still driven");
    chk_side_excl: assert property (!(o_pin.hs_on && o_pin.ls_on))
        else $error("both switch sides on");
    chk_fail_cause: assert property ($rose(o_pin.fail_output) |-> $past(i_fail_req))
        else $error("fail output without request");
    chk_wrap_pulse: assert property (o_pwm_wrap |=> !o_pwm_wrap)
        else $error("wrap longer than one cycle");
    chk_wake_pulse: assert property (o_wake_event |=> !o_wake_event)
        else $error("wake event longer than one cycle");
endmodule
bind hcg_config_regs hcg_config_regs_chk u_chk (.i_sys_clk, .i_rst, .i_spi_cs_n, .i_fail_req,
    .o_spi_miso_oe, .o_pin, .o_wake_event, .o_cfg, .o_pwm_wrap);
`default_nettype wire

// [bench/hcg_spi_host.sv]
// host serial master model driving lsb-first frames
`timescale 1ns/1ps
`default_nettype none
module hcg_spi_host (
    // clock
    input  wire logic i_sys_clk,
    // serial lines
    output logic      o_cs_n,
    output logic      o_sclk,
    output logic      o_mosi,
    input  wire logic i_miso
);
    int half = 10;
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_mosi = 1'b0;
    end
    // read byte sampled at the end of each late low phase
    task automatic xfer(input logic [6:0] a, input logic w, input logic [7:0] d,
                        output logic [7:0] q);
        logic [15:0] f;
        f = {d, w, a};
        q = 8'h00;
        @(posedge i_sys_clk) o_cs_n <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            @(posedge i_sys_clk) o_sclk <= 1'b0;
            o_mosi <= f[i];
            repeat (half) @(posedge i_sys_clk);
            if (i > 7) q[i-8] = i_miso;
            o_sclk <= 1'b1;
            repeat (half) @(posedge i_sys_clk);
        end
        o_sclk <= 1'b0;
        repeat (half) @(posedge i_sys_clk);
        o_cs_n <= 1'b1;
        o_mosi <= ~o_mosi;
        repeat (12) @(posedge i_sys_clk);
    endtask
endmodule
`default_nettype wire

// [bench/test_hw_config_lock_gpio_pwm.sv]
// self-checking bench for the configuration register slice
`timescale 1ns/1ps
`default_nettype none
module test_hw_config_lock_gpio_pwm
    import hcg_pkg::*;
;
    logic       i_sys_clk = 1'b0;
    logic       i_rst = 1'b1;
    logic       soft_rst = 1'b0, restart = 1'b0, lock0 = 1'b0, pin_in = 1'b0;
    logic       tmr_on = 1'b1, fail_req = 1'b1;
    logic       cs_n, sclk, mosi, miso;
    logic       miso_oe, miso_ln, wake_lvl, wake_evt;
    int         n_wake = 0;
    logic [7:0] rd, v;
    hcg_pin_t   pin_o;
    hcg_cfg_t   cfg_o;
    int         n_errors = 0, comparisons = 0;
    always #5 i_sys_clk = ~i_sys_clk;
    hcg_config_regs u_dut (.i_sys_clk, .i_rst, .i_spi_cs_n(cs_n), .i_spi_sclk(sclk),
        .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe(miso_oe), .i_soft_rst(soft_rst),
        .i_restart(restart), .i_cfg_lock0(lock0), .i_cs_timer_on(tmr_on), .i_fail_req(fail_req),
        .i_pin_in(pin_in), .o_pin(pin_o), .o_wake_event(wake_evt), .o_wake_level(wake_lvl),
        .o_cfg(cfg_o), .o_pwm_wrap());
    // pull-up on the released data line
    assign miso_ln = miso_oe ? miso : 1'b1;
    hcg_spi_host u_host (.i_sys_clk, .o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi),
        .i_miso(miso_ln));
    always @(posedge i_sys_clk) begin
        if (wake_evt === 1'b1)
            n_wake <= n_wake + 1;
    end
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic rdchk(input string name, input logic [6:0] a, input logic [7:0] exp);
        u_host.xfer(a, 1'b0, 8'h00, rd);
        check(name, rd, exp);
    endtask
    // pin outputs for a mode, timer on-time and fail request
    function automatic logic [7:0] exp_pin(input logic [2:0] m, input logic t, input logic f);
        return {4'h0, f && m <= PM_FAIL_LAST, t && m == PM_CYCLIC_HS, 1'b0, m == PM_WAKE};
    endfunction
    task automatic complete_run();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge i_sys_clk);
        n_errors++;
        complete_run();
    end
    initial begin
        void'($urandom(98879));
        repeat (2) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        rdchk("hw2 por", 7'h0f, 8'h40);
        rdchk("unmapped", 7'h33, 8'h00);
        v = 8'($urandom);
        u_host.xfer(7'h18, 1'b1, v, rd);
        rdchk("duty", 7'h18, v);
        v = 8'($urandom);
        u_host.xfer(7'h1c, 1'b1, v, rd);
        rdchk("rate", 7'h1c, v & 8'h03);
        for (int k = 0; k < 4; k++) begin
            v = (k == 0) ? 8'hfe : 8'($urandom) & 8'hfe;
            u_host.xfer(7'h0f, 1'b1, v, rd);
            check("cfg", 8'(cfg_o), {1'b0, v[7:2], v[0]});
            rdchk("hw2", 7'h0f, v & 8'hfd);
        end
        for (int m = 0; m < 8; m++) begin
            fail_req <= (m != 1);
            u_host.xfer(7'h17, 1'b1, {5'($urandom), 3'(m)}, rd);
            check("pin out", 8'(pin_o), exp_pin(3'(m), 1'b1, m != 1));
            if (m == 3) begin
                tmr_on <= 1'b0;
                repeat (3) @(posedge i_sys_clk);
                check("pin timer off", 8'(pin_o), exp_pin(3'(m), 1'b0, 1'b1));
                tmr_on <= 1'b1;
            end
            if (m == 5) begin
                pin_in <= 1'b1;
                repeat (WAKE_FILT_CYC - 100) @(posedge i_sys_clk);
                check("wake early", {7'h00, wake_lvl}, 8'h00);
                repeat (200) @(posedge i_sys_clk);
                check("wake level", {7'h00, wake_lvl}, 8'h01);
                check("wake events", 8'(n_wake), 8'h01);
            end
            rdchk("pin", 7'h17, 8'(m));
        end
        @(posedge i_sys_clk) restart <= 1'b1;
        @(posedge i_sys_clk) restart <= 1'b0;
        rdchk("pin restart", 7'h17, 8'h04);
        lock0 <= 1'b1;
        u_host.xfer(7'h17, 1'b1, 8'h05, rd);
        rdchk("pin lock0", 7'h17, 8'h04);
        u_host.half = 16;
        u_host.xfer(7'h0f, 1'b1, 8'h9d, rd);
        rdchk("lock set", 7'h0f, 8'h9d);
        u_host.xfer(7'h0f, 1'b1, 8'h40, rd);
        rdchk("lock hold", 7'h0f, 8'h9d);
        @(posedge i_sys_clk) soft_rst <= 1'b1;
        @(posedge i_sys_clk) soft_rst <= 1'b0;
        rdchk("lock soft", 7'h0f, 8'h9d);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        rdchk("lock por", 7'h0f, 8'h40);
        complete_run();
    end
endmodule
`default_nettype wire

// [hw/hcg_config_regs.sv]
// configuration registers with lock, pin mode selector and pwm behind serial port
//
// Function
// - bits 7:5 select switching frequency, 2.2 default
// - bit 4 selects low or high peak
// - bits 3:2 select spread spectrum rate
// - reserved bits always read as zero
// - lock one freezes lockable bits until power-up
// - lock enforced from chip-select rise after write
// - lock protects itself, survives soft reset
// - locked soft reset keeps configured values
// - power-up defaults, low-power exits keep values, clear rate bit 1
// - pin mode codes: fail, off, pwm sides
// - code 011 high side gated by timer
// - code 101 wake input, 16 us filter
// - restart pin mode depends on current mode
// - wake-mode pin is fail-safe wake source
// - duty 0 off, 255 on, else n/255
// - new duty applied after current period
// - bits 1:0 select 100/200/325/400 hz
// - rate change applied after current period
// - lock zero blocks pin mode writes
`timescale 1ns/1ps
`default_nettype none

module hcg_config_regs
    import hcg_pkg::*;
(
    // clock and reset
    input  wire logic     i_sys_clk,
    input  wire logic     i_rst,
    // serial port
    input  wire logic     i_spi_cs_n,
    input  wire logic     i_spi_sclk,
    input  wire logic     i_spi_mosi,
    output logic          o_spi_miso,
    output logic          o_spi_miso_oe,
    // device state
    input  wire logic     i_soft_rst,
    input  wire logic     i_restart,
    input  wire logic     i_cfg_lock0,
    input  wire logic     i_cs_timer_on,
    input  wire logic     i_fail_req,
    // multi-function pin
    input  wire logic     i_pin_in,
    output hcg_pin_t      o_pin,
    output logic          o_wake_event,
    output logic          o_wake_level,
    // applied settings
    output hcg_cfg_t      o_cfg,
    output logic          o_pwm_wrap
);

    logic [SYNC_W-1:0]     sync1_reg;
    logic [SYNC_W-1:0]     sync2_reg;
    logic [SYNC_W-1:0]     sync3_reg;
    logic [SYNC_W-1:0]     filt_reg;
    logic [SYNC_W-1:0]     filt_d_reg;
    logic                  sclk_rise;
    logic                  sclk_fall;
    logic                  cs_rise;
    logic                  cs_fall;
    logic                  cs_low;
    logic [CNT_W-1:0]      bit_cnt_reg;
    logic [15:0]           shift_in_reg;
    logic [7:0]            miso_shift_reg;
    logic                  frame_ok;
    logic                  wr_stb;
    logic [ADDR_W-1:0]     wr_addr;
    logic [DATA_W-1:0]     wr_data;
    logic [7:0]            hw2_reg;
    logic [7:0]            pin_reg;
    logic [7:0]            duty_reg;
    logic [7:0]            rate_reg;
    logic                  lock1;
    logic [2:0]            mode;
    logic                  pwm_on;
    logic                  wake_lvl_reg;
    logic [WAKE_CNT_W-1:0] wake_cnt_reg;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // register read with reserved bits forced low
    function automatic logic [7:0] read_mux(input logic [ADDR_W-1:0] a,
                                            input logic [7:0] h2,
                                            input logic [7:0] pf,
                                            input logic [7:0] du,
                                            input logic [7:0] ra);
        if (a == ADDR_HW_CTRL_TWO)
            read_mux = h2 & HW2_MASK;
        else if (a == ADDR_PIN_FUNC_SEL)
            read_mux = pf & PIN_MASK;
        else if (a == ADDR_PULSE_DUTY)
            read_mux = du & DUTY_MASK;
        else if (a == ADDR_PULSE_RATE)
            read_mux = ra & RATE_MASK;
        else
            read_mux = 8'h00;
    endfunction

    // pin mode kept or dropped to off by restart
    function automatic logic [7:0] pin_restart(input logic [7:0] pf);
        if (pf[MODE_MSB:0] == PM_CYCLIC_HS || pf[MODE_MSB:0] == PM_PWM_LS ||
            pf[MODE_MSB:0] == PM_PWM_HS)
            pin_restart = {5'h00, PM_OFF};
        else
            pin_restart = pf & PIN_MASK;
    endfunction

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            sync1_reg <= SYNC_RST;
            sync2_reg <= SYNC_RST;
            sync3_reg <= SYNC_RST;
        end else begin
            sync1_reg <= {i_pin_in, i_spi_cs_n, i_spi_sclk, i_spi_mosi};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // a lane changes only once stages two and three agree
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            filt_reg   <= SYNC_RST;
            filt_d_reg <= SYNC_RST;
        end else begin
            for (int i = 0; i < SYNC_W; i++) begin
                if (sync2_reg[i] == sync3_reg[i])
                    filt_reg[i] <= sync3_reg[i];
            end
            filt_d_reg <= filt_reg;
        end
    end

    assign cs_low    = ~filt_reg[LN_CS_N];
    assign cs_rise   = filt_reg[LN_CS_N] & ~filt_d_reg[LN_CS_N];
    assign cs_fall   = ~filt_reg[LN_CS_N] & filt_d_reg[LN_CS_N];
    assign sclk_rise = cs_low & filt_reg[LN_SCLK] & ~filt_d_reg[LN_SCLK];
    assign sclk_fall = cs_low & ~filt_reg[LN_SCLK] & filt_d_reg[LN_SCLK];

    // ------------------------------------------------------------------
    // serial frame: lsb first, addr 6:0, write flag, data
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            bit_cnt_reg  <= '0;
            shift_in_reg <= '0;
        end else if (cs_fall) begin
            bit_cnt_reg  <= '0;
        end else if (sclk_rise) begin
            shift_in_reg <= {filt_reg[LN_MOSI], shift_in_reg[15:1]};
            if (bit_cnt_reg <= FRAME_BITS)
                bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            miso_shift_reg <= '0;
        end else if (cs_fall) begin
            miso_shift_reg <= '0;
        end else if (sclk_rise && bit_cnt_reg == ADDR_DONE_BITS) begin
            miso_shift_reg <= read_mux(shift_in_reg[15:ADDR_LSB], hw2_reg, pin_reg,
                                       duty_reg, rate_reg);
        end else if (sclk_fall && bit_cnt_reg >= MISO_SHIFT_MIN) begin
            miso_shift_reg <= {1'b0, miso_shift_reg[7:1]};
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_spi_miso    <= 1'b0;
            o_spi_miso_oe <= 1'b0;
        end else begin
            o_spi_miso    <= miso_shift_reg[0];
            o_spi_miso_oe <= cs_low;
        end
    end

    // writes land on the chip-select rise of a whole frame
    assign frame_ok = cs_rise && (bit_cnt_reg == FRAME_BITS);
    assign wr_stb   = frame_ok && shift_in_reg[WR_FLAG_BIT];
    assign wr_addr  = shift_in_reg[ADDR_W-1:0];
    assign wr_data  = shift_in_reg[15:DATA_LSB];

    // ------------------------------------------------------------------
    // hardware control two
    // ------------------------------------------------------------------
    assign lock1 = hw2_reg[LOCK1_BIT];

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            hw2_reg <= HW2_POR;
        end else if (i_soft_rst) begin
            if (!lock1)
                hw2_reg <= (HW2_POR & ~LOCK1_MASK) | (hw2_reg & LOCK1_MASK);
            // locked: soft reset keeps the configured content
        end else if (i_restart) begin
            hw2_reg <= hw2_reg;
        end else if (wr_stb && wr_addr == ADDR_HW_CTRL_TWO && !lock1) begin
            // lock bit seen is the one set by an earlier frame
            hw2_reg <= wr_data & HW2_MASK;
        end
    end

    // applied analog settings
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_cfg <= '{switch_freq_sel: HW2_POR[SFREQ_MSB:SFREQ_LSB],
                       peak_current_thr_sel: HW2_POR[PEAK_BIT],
                       spread_mod_rate: HW2_POR[SPREAD_MSB:SPREAD_LSB],
                       lock1: HW2_POR[LOCK1_BIT]};
        end else begin
            o_cfg.switch_freq_sel      <= hw2_reg[SFREQ_MSB:SFREQ_LSB];
            o_cfg.peak_current_thr_sel <= hw2_reg[PEAK_BIT];
            o_cfg.spread_mod_rate      <= hw2_reg[SPREAD_MSB:SPREAD_LSB];
            o_cfg.lock1                <= lock1;
        end
    end

    // ------------------------------------------------------------------
    // pin function select
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            pin_reg <= PIN_POR;
        end else if (i_soft_rst && !i_cfg_lock0) begin
            pin_reg <= PIN_POR;
        end else if (i_soft_rst || i_restart) begin
            pin_reg <= pin_restart(pin_reg);
        end else if (wr_stb && wr_addr == ADDR_PIN_FUNC_SEL && !i_cfg_lock0) begin
            pin_reg <= wr_data & PIN_MASK;
        end
    end

    assign mode = pin_reg[MODE_MSB:0];

    // ------------------------------------------------------------------
    // pulse duty and rate
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            duty_reg <= DUTY_POR;
        end else if (i_soft_rst) begin
            duty_reg <= DUTY_POR;
        end else if (wr_stb && wr_addr == ADDR_PULSE_DUTY) begin
            duty_reg <= wr_data & DUTY_MASK;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            rate_reg <= RATE_POR;
        end else if (i_soft_rst) begin
            rate_reg <= RATE_POR;
        end else if (i_restart) begin
            rate_reg <= rate_reg & RATE_KEEP_MASK;
        end else if (wr_stb && wr_addr == ADDR_PULSE_RATE) begin
            rate_reg <= wr_data & RATE_MASK;
        end
    end

    hcg_pwm_gen u_pwm (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_duty    (duty_reg),
        .i_rate    (rate_reg[RATE_MSB:0]),
        .o_pwm_on  (pwm_on),
        .o_wrap    (o_pwm_wrap)
    );

    // ------------------------------------------------------------------
    // wake input filter
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            wake_lvl_reg <= 1'b0;
            wake_cnt_reg <= '0;
            o_wake_event <= 1'b0;
        end else begin
            o_wake_event <= 1'b0;
            if (mode != PM_WAKE) begin
                wake_lvl_reg <= filt_reg[LN_PIN];
                wake_cnt_reg <= '0;
            end else if (filt_reg[LN_PIN] == wake_lvl_reg) begin
                wake_cnt_reg <= '0;
            end else if (wake_cnt_reg == WAKE_CNT_W'(WAKE_FILT_CYC - 1)) begin
                // level stable for the full filter time
                wake_lvl_reg <= filt_reg[LN_PIN];
                wake_cnt_reg <= '0;
                o_wake_event <= 1'b1;
            end else begin
                wake_cnt_reg <= wake_cnt_reg + 11'h001;
            end
        end
    end

    assign o_wake_level = wake_lvl_reg;

    // ------------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pin <= '0;
        end else begin
            o_pin.fail_output       <= (mode <= PM_FAIL_LAST) && i_fail_req;
            o_pin.hs_on             <= ((mode == PM_CYCLIC_HS) && i_cs_timer_on) ||
                                       ((mode == PM_PWM_HS) && pwm_on);
            o_pin.ls_on             <= (mode == PM_PWM_LS) && pwm_on;
            o_pin.wake_src_failsafe <= (mode == PM_WAKE);
        end
    end

endmodule

`default_nettype wire

// [hw/hcg_pwm_gen.sv]
// pwm duty and rate generator with period-boundary latching
`timescale 1ns/1ps
`default_nettype none

module hcg_pwm_gen
    import hcg_pkg::*;
(
    // clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst,
    // settings
    input  wire logic [7:0] i_duty,
    input  wire logic [1:0] i_rate,
    // output
    output logic            o_pwm_on,
    output logic            o_wrap
);

    logic [DIV_W-1:0] div_cnt_reg;
    logic [7:0]       step_reg;
    logic [7:0]       duty_act_reg;
    logic [1:0]       rate_act_reg;
    logic             div_done;
    logic             wrap;

    // ------------------------------------------------------------------
    // step divisor per rate
    // ------------------------------------------------------------------
    function automatic logic [DIV_W-1:0] rate_div(input logic [1:0] sel);
        unique case (sel)
            2'h0: rate_div = DIV0;
            2'h1: rate_div = DIV1;
            2'h2: rate_div = DIV2;
            2'h3: rate_div = DIV3;
        endcase
    endfunction

    assign div_done = (div_cnt_reg == rate_div(rate_act_reg) - 12'h001);
    assign wrap     = div_done && (step_reg == PWM_LAST_STEP);

    // 255 steps per period
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            div_cnt_reg <= '0;
            step_reg    <= '0;
        end else if (div_done) begin
            div_cnt_reg <= '0;
            step_reg    <= wrap ? 8'h00 : step_reg + 8'h01;
        end else begin
            div_cnt_reg <= div_cnt_reg + 12'h001;
        end
    end

    // new settings only at the period wrap
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            duty_act_reg <= DUTY_POR;
            rate_act_reg <= '0;
        end else if (wrap) begin
            duty_act_reg <= i_duty;
            rate_act_reg <= i_rate;
        end
    end

    // on for n of 255 steps, 0 off, 255 on
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pwm_on <= 1'b0;
            o_wrap   <= 1'b0;
        end else begin
            o_pwm_on <= (duty_act_reg == DUTY_FULL) ||
                        ((duty_act_reg != DUTY_OFF) && (step_reg < duty_act_reg));
            o_wrap   <= wrap;
        end
    end

endmodule

`default_nettype wire

// [inc/hcg_pkg.sv]
// shared constants and types for the configuration lock, pin mode and pwm block
package hcg_pkg;

    // ------------------------------------------------------------------
    // serial frame
    // ------------------------------------------------------------------
    localparam int          ADDR_W         = 7;
    localparam int          DATA_W         = 8;
    localparam int          CNT_W          = 5;
    localparam logic [4:0]  FRAME_BITS     = 5'h10;
    localparam logic [4:0]  ADDR_DONE_BITS = 5'h07;
    localparam logic [4:0]  MISO_SHIFT_MIN = 5'h09;
    localparam int          WR_FLAG_BIT    = 7;
    localparam int          ADDR_LSB       = 9;
    localparam int          DATA_LSB       = 8;

    // synchroniser lanes
    localparam int          SYNC_W         = 4;
    localparam int          LN_MOSI        = 0;
    localparam int          LN_SCLK        = 1;
    localparam int          LN_CS_N        = 2;
    localparam int          LN_PIN         = 3;
    localparam logic [3:0]  SYNC_RST       = 4'h4;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [6:0]  ADDR_HW_CTRL_TWO   = 7'h0f;
    localparam logic [6:0]  ADDR_PIN_FUNC_SEL  = 7'h17;
    localparam logic [6:0]  ADDR_PULSE_DUTY    = 7'h18;
    localparam logic [6:0]  ADDR_PULSE_RATE    = 7'h1c;

    // ------------------------------------------------------------------
    // reset values and writable masks
    // ------------------------------------------------------------------
    localparam logic [7:0]  HW2_POR        = 8'h40;
    localparam logic [7:0]  PIN_POR        = 8'h00;
    localparam logic [7:0]  DUTY_POR       = 8'h00;
    localparam logic [7:0]  RATE_POR       = 8'h00;
    localparam logic [7:0]  HW2_MASK       = 8'hfd;
    localparam logic [7:0]  LOCK1_MASK     = 8'h01;
    localparam logic [7:0]  PIN_MASK       = 8'h07;
    localparam logic [7:0]  DUTY_MASK      = 8'hff;
    localparam logic [7:0]  RATE_MASK      = 8'h03;
    localparam logic [7:0]  RATE_KEEP_MASK = 8'h01;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int          SFREQ_MSB      = 7;
    localparam int          SFREQ_LSB      = 5;
    localparam int          PEAK_BIT       = 4;
    localparam int          SPREAD_MSB     = 3;
    localparam int          SPREAD_LSB     = 2;
    localparam int          LOCK1_BIT      = 0;
    localparam int          MODE_MSB       = 2;
    localparam int          RATE_MSB       = 1;

    // ------------------------------------------------------------------
    // pin mode codes
    // ------------------------------------------------------------------
    localparam logic [2:0]  PM_FAIL_A      = 3'h0;
    localparam logic [2:0]  PM_FAIL_LAST   = 3'h2;
    localparam logic [2:0]  PM_CYCLIC_HS   = 3'h3;
    localparam logic [2:0]  PM_OFF         = 3'h4;
    localparam logic [2:0]  PM_WAKE        = 3'h5;
    localparam logic [2:0]  PM_PWM_LS      = 3'h6;
    localparam logic [2:0]  PM_PWM_HS      = 3'h7;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int          SYS_CLK_HZ     = 100_000_000;
    localparam int          WAKE_FILT_US   = 16;
    localparam int          WAKE_FILT_CYC  = SYS_CLK_HZ / 1_000_000 * WAKE_FILT_US;
    localparam int          WAKE_CNT_W     = 11;
    localparam int          PWM_STEPS      = 255;
    localparam logic [7:0]  PWM_LAST_STEP  = 8'hfe;
    localparam logic [7:0]  DUTY_OFF       = 8'h00;
    localparam logic [7:0]  DUTY_FULL      = 8'hff;
    localparam int          RATE0_HZ       = 100;
    localparam int          RATE1_HZ       = 200;
    localparam int          RATE2_HZ       = 325;
    localparam int          RATE3_HZ       = 400;
    localparam int          DIV_W          = 12;
    localparam logic [11:0] DIV0 = 12'(SYS_CLK_HZ / (RATE0_HZ * PWM_STEPS));
    localparam logic [11:0] DIV1 = 12'(SYS_CLK_HZ / (RATE1_HZ * PWM_STEPS));
    localparam logic [11:0] DIV2 = 12'(SYS_CLK_HZ / (RATE2_HZ * PWM_STEPS));
    localparam logic [11:0] DIV3 = 12'(SYS_CLK_HZ / (RATE3_HZ * PWM_STEPS));

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] switch_freq_sel;
        logic       peak_current_thr_sel;
        logic [1:0] spread_mod_rate;
        logic       lock1;
    } hcg_cfg_t;

    typedef struct packed {
        logic       fail_output;
        logic       hs_on;
        logic       ls_on;
        logic       wake_src_failsafe;
    } hcg_pin_t;

endpackage
